// [hw/gpio_share_pkg.sv]
// Constants for the twelve-pin port block: register map, fields, reset values.
package gpio_share_pkg;

  // Bus geometry
  localparam int          ADDR_W         = 12;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // Printed register indices; byte address is four times the index
  localparam logic [9:0]  IDX_P0_DIR     = 10'h0b8;
  localparam logic [9:0]  IDX_P4_DIR     = 10'h0c4;
  localparam logic [9:0]  IDX_P5_DIR     = 10'h0c5;

  // Further registers, given as byte addresses
  localparam logic [11:0] ADR_P0_DATA    = 12'h000;
  localparam logic [11:0] ADR_P4_DATA    = 12'h004;
  localparam logic [11:0] ADR_P5_DATA    = 12'h008;
  localparam logic [11:0] ADR_INT_STATUS = 12'h00c;
  localparam logic [11:0] ADR_INT_MASK   = 12'h010;
  localparam logic [11:0] ADR_EDGE_CTRL  = 12'h014;
  localparam logic [11:0] ADR_OPTIONS    = 12'h018;
  localparam logic [11:0] ADR_TIMER_CTRL = 12'h01c;
  localparam logic [11:0] ADR_ADC_CTRL   = 12'h020;
  // Bit set / bit clear aliases of the direction registers
  localparam logic [11:0] ADR_DIR_SET0   = 12'h100;
  localparam logic [11:0] ADR_DIR_CLR0   = 12'h104;
  localparam logic [11:0] ADR_DIR_SET4   = 12'h108;
  localparam logic [11:0] ADR_DIR_CLR4   = 12'h10c;
  localparam logic [11:0] ADR_DIR_SET5   = 12'h110;
  localparam logic [11:0] ADR_DIR_CLR5   = 12'h114;

  // Field positions
  localparam int P5_LO_BIT   = 3;   // Port 5 pins sit at bits 4:3
  localparam int OPT_EXTRST  = 0;   // Options: external reset on port 0 bit 4
  localparam int OPT_HCLK_LO = 1;   // Options: high clock mode, bits 3:1
  localparam int TMR_A_EN    = 0;
  localparam int TMR_B_EN    = 1;
  localparam int TMR_A_OSEL  = 2;
  localparam int TMR_B_OSEL  = 3;
  localparam int PLS_A_OSEL  = 4;
  localparam int PLS_B_OSEL  = 5;
  localparam int ADC_CHS_LO  = 0;   // Channel field, bits 2:0
  localparam int ADC_GLOBAL_CHANNEL_SELECT    = 4;
  localparam int ADC_EVH     = 5;
  localparam int ADC_EN      = 7;

  // High clock modes
  localparam logic [2:0] HCLK_INTERNAL = 3'h0;
  localparam logic [2:0] HCLK_RC       = 3'h1;
  localparam logic [2:0] HCLK_32K      = 3'h2;
  localparam logic [2:0] HCLK_4M       = 3'h3;
  localparam logic [2:0] HCLK_12M      = 3'h4;

  // Edge select codes for pin 0 interrupt
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Reset values
  localparam logic [7:0] DIR_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [1:0] EDGE_RESET  = EDGE_FALL;
  localparam logic [3:0] OPT_RESET   = 4'h0;

endpackage : gpio_share_pkg

// [hw/gpio_share.sv]
// Twelve-pin I/O port with direction, pin sharing, external interrupt flags.
`timescale 1ns/1ps
`default_nettype none

module gpio_share
  import gpio_share_pkg::*;
(
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RESET_N,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Port 0 pads, bit 4 input only
  input  wire logic [4:0]        P0_IN,
  output logic [3:0]             P0_OUT,
  output logic [3:0]             P0_OE,
  // Port 4 pads
  input  wire logic [4:0]        P4_IN,
  output logic [4:0]             P4_OUT,
  output logic [4:0]             P4_OE,
  // Port 5 pads, index 0 is pin 3 and index 1 is pin 4
  input  wire logic [1:0]        P5_IN,
  output logic [1:0]             P5_OUT,
  output logic [1:0]             P5_OE,
  // Timer waveforms to be routed onto port 5
  input  wire logic              TIMER_A_PULSE,
  input  wire logic              TIMER_A_BUZZ,
  input  wire logic              TIMER_B_PULSE,
  input  wire logic              TIMER_B_BUZZ,
  // Shared function selects towards analog, clock and reset logic
  output logic [4:0]             ANALOG_SEL,
  output logic                   HIGH_REF_SEL,
  output logic                   OSC_IN_SEL,
  output logic                   OSC_OUT_SEL,
  output logic                   EXT_RESET_REQ,
  // Interrupt
  output logic                   IRQ
);

  // Whole block state in one word: reset and update stay in one place,
  // at the cost of a wide register that clears in a single stroke
  typedef struct packed {
    logic [3:0]        dir0;
    logic [4:0]        dir4;
    logic [1:0]        dir5;
    logic [3:0]        dat0;
    logic [4:0]        dat4;
    logic [1:0]        dat5;
    logic [1:0]        int_en;
    logic [1:0]        int_req;
    logic [1:0]        edge_sel;
    logic [3:0]        options;
    logic [5:0]        tmr;
    logic [7:0]        adc;
    logic [1:0]        pin_prev;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [3:0]        p0_out;
    logic [3:0]        p0_oe;
    logic [4:0]        p4_out;
    logic [4:0]        p4_oe;
    logic [1:0]        p5_out;
    logic [1:0]        p5_oe;
    logic [4:0]        analog_sel;
    logic              high_ref;
    logic              osc_in;
    logic              osc_out;
    logic              ext_rst;
    logic              irq;
  } state_t;

  // Registered copy and its combinational next value
  state_t st_reg;
  state_t st_next;

  // Printed index to byte address
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [9:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction : idx_addr

  // Address decode shared by read and write paths
  // Holes in the map answer SLVERR, read as zero, change nothing
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == idx_addr(IDX_P0_DIR)) || (a == idx_addr(IDX_P4_DIR)) ||
             (a == idx_addr(IDX_P5_DIR)) || (a <= ADR_ADC_CTRL && a[1:0] == 2'b00) ||
             (a >= ADR_DIR_SET0 && a <= ADR_DIR_CLR5 && a[1:0] == 2'b00);
  endfunction : mapped

  // Settle the pin view: when external reset owns bit 4 it reads high
  logic [4:0] p0_view;
  always_comb begin
    p0_view    = P0_IN;
    p0_view[4] = st_reg.options[OPT_EXTRST] ? 1'b1 : P0_IN[4];
  end

  // Read multiplexer, eight live bits, upper bits read as zero
  function automatic logic [7:0] read_value(input state_t s, input logic [4:0] p0v,
                                            input logic [4:0] p4v, input logic [1:0] p5v,
                                            input logic [ADDR_W-1:0] a);
    read_value = 8'h00;
    if (a == idx_addr(IDX_P0_DIR)) read_value = {4'h0, s.dir0};
    else if (a == idx_addr(IDX_P4_DIR)) read_value = {3'h0, s.dir4};
    else if (a == idx_addr(IDX_P5_DIR)) read_value = {3'h0, s.dir5, 3'h0};
    else begin
      unique case (a)
        ADR_P0_DATA:    read_value = {3'h0, p0v};
        ADR_P4_DATA:    read_value = {3'h0, p4v};
        ADR_P5_DATA:    read_value = {3'h0, p5v, 3'h0};
        ADR_INT_STATUS: read_value = {6'h00, s.int_req};
        ADR_INT_MASK:   read_value = {6'h00, s.int_en};
        ADR_EDGE_CTRL:  read_value = {6'h00, s.edge_sel};
        ADR_OPTIONS:    read_value = {4'h0, s.options};
        ADR_TIMER_CTRL: read_value = {2'h0, s.tmr};
        ADR_ADC_CTRL:   read_value = s.adc;
        default:        read_value = 8'h00;
      endcase
    end
  endfunction : read_value

  // Next-state logic: bus slave, register writes, edge flags, pin sharing
  always_comb begin
    logic       do_write;
    logic [7:0] wd;
    logic [1:0] edge_hit;
    logic [1:0] clear_req;
    logic [2:0] hclk;
    logic       conv_on;
    logic [4:0] chan_hit;
    logic       a_pulse;
    logic       a_buzz;
    logic       b_pulse;
    logic       b_buzz;
    logic [4:0] p4_analog;
    do_write  = 1'b0;
    wd        = 8'h00;
    edge_hit  = 2'b00;
    clear_req = 2'b00;
    hclk      = 3'h0;
    conv_on   = 1'b0;
    chan_hit  = 5'h00;
    a_pulse   = 1'b0;
    a_buzz    = 1'b0;
    b_pulse   = 1'b0;
    b_buzz    = 1'b0;
    p4_analog = 5'h00;
    st_next   = st_reg;

    // Write address and data are taken independently, in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_next.w_have  = 1'b1;
      st_next.w_data  = S_AXI_WDATA[7:0];
      st_next.w_lane0 = S_AXI_WSTRB[0];
    end

    // Perform the write once both halves are held and no response is pending
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      // Without lane 0 a mapped write is answered OKAY but changes nothing
      do_write        = mapped(st_reg.aw_addr) && st_reg.w_lane0;
      wd              = st_reg.w_data;
    end
    if (st_reg.bvalid && S_AXI_BREADY) begin
      st_next.bvalid = 1'b0;
    end

    // Register writes; set and clear aliases touch only the bits written as one
    if (do_write) begin
      if (st_reg.aw_addr == idx_addr(IDX_P0_DIR)) st_next.dir0 = wd[3:0];
      else if (st_reg.aw_addr == idx_addr(IDX_P4_DIR)) st_next.dir4 = wd[4:0];
      else if (st_reg.aw_addr == idx_addr(IDX_P5_DIR)) st_next.dir5 = wd[4:3];
      else begin
        unique case (st_reg.aw_addr)
          ADR_P0_DATA:    st_next.dat0     = wd[3:0];
          ADR_P4_DATA:    st_next.dat4     = wd[4:0];
          ADR_P5_DATA:    st_next.dat5     = wd[4:3];
          ADR_INT_STATUS: clear_req        = wd[1:0];
          ADR_INT_MASK:   st_next.int_en   = wd[1:0];
          ADR_EDGE_CTRL:  st_next.edge_sel = wd[1:0];
          ADR_OPTIONS:    st_next.options  = wd[3:0];
          ADR_TIMER_CTRL: st_next.tmr      = wd[5:0];
          ADR_ADC_CTRL:   st_next.adc      = {wd[7], 1'b0, wd[5:4], 1'b0, wd[2:0]};
          ADR_DIR_SET0:   st_next.dir0     = st_reg.dir0 | wd[3:0];
          ADR_DIR_CLR0:   st_next.dir0     = st_reg.dir0 & ~wd[3:0];
          ADR_DIR_SET4:   st_next.dir4     = st_reg.dir4 | wd[4:0];
          ADR_DIR_CLR4:   st_next.dir4     = st_reg.dir4 & ~wd[4:0];
          ADR_DIR_SET5:   st_next.dir5     = st_reg.dir5 | wd[4:3];
          ADR_DIR_CLR5:   st_next.dir5     = st_reg.dir5 & ~wd[4:3];
          default:        st_next.dat0     = st_reg.dat0;
        endcase
      end
    end

    // Read channel: one read at a time, data held until accepted
    // Pads are sampled at the address edge, so a read shows them one clock old
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = read_value(st_reg, p0_view, P4_IN, P5_IN, S_AXI_ARADDR);
      st_next.rresp  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.rvalid && S_AXI_RREADY) begin
      st_next.rvalid = 1'b0;
    end

    // Edge detection; flags set whatever the enable, and set beats clear
    // Edge code 3 is undefined and falls back to the falling edge
    st_next.pin_prev = P0_IN[1:0];
    edge_hit[1] = st_reg.pin_prev[1] && !P0_IN[1];
    unique case (st_reg.edge_sel)
      EDGE_RISE: edge_hit[0] = !st_reg.pin_prev[0] && P0_IN[0];
      EDGE_BOTH: edge_hit[0] = st_reg.pin_prev[0] != P0_IN[0];
      default:   edge_hit[0] = st_reg.pin_prev[0] && !P0_IN[0];
    endcase
    st_next.int_req = (st_reg.int_req & ~clear_req) | edge_hit;
    // Only enabled requests reach the interrupt line
    // Next-state values let IRQ rise with its flag, not a clock later
    st_next.irq = |(st_next.int_req & st_next.int_en);

    // Clock and reset pin ownership
    // Modes 5 to 7 select no oscillator, so both pads stay plain I/O
    hclk             = st_next.options[OPT_HCLK_LO +: 3];
    st_next.osc_in   = (hclk == HCLK_RC) || (hclk == HCLK_32K) ||
                       (hclk == HCLK_4M) || (hclk == HCLK_12M);
    st_next.osc_out  = (hclk == HCLK_32K) || (hclk == HCLK_4M) ||
                       (hclk == HCLK_12M);
    st_next.ext_rst  = st_next.options[OPT_EXTRST] && !P0_IN[4];

    // Analog channel routing on port 4
    // Channel codes 5 to 7 point at no pad of this port
    conv_on = st_next.adc[ADC_EN];
    for (int i = 0; i < 5; i++) begin
      chan_hit[i] = conv_on && st_next.adc[ADC_GLOBAL_CHANNEL_SELECT] &&
                    (st_next.adc[ADC_CHS_LO +: 3] == 3'(i));
    end
    st_next.analog_sel = chan_hit;
    st_next.high_ref   = conv_on && st_next.adc[ADC_EVH];
    p4_analog          = chan_hit | {4'h0, st_next.high_ref};

    // Timer outputs: pulse wins, buzzer only with pulse select clear
    // Limitation: waveforms pass a flip-flop and reach the pads a clock late
    a_pulse = st_next.tmr[TMR_A_EN] && st_next.tmr[PLS_A_OSEL];
    a_buzz  = st_next.tmr[TMR_A_EN] && st_next.tmr[TMR_A_OSEL] && !st_next.tmr[PLS_A_OSEL];
    b_pulse = st_next.tmr[TMR_B_EN] && st_next.tmr[PLS_B_OSEL];
    b_buzz  = st_next.tmr[TMR_B_EN] && st_next.tmr[TMR_B_OSEL] && !st_next.tmr[PLS_B_OSEL];

    // Port 0 pads; bit 4 has no driver at all
    // Direction bit 4 is never stored, so writing it enables nothing
    st_next.p0_out = st_next.dat0;
    st_next.p0_oe  = st_next.dir0;
    if (st_next.osc_in) begin
      st_next.p0_oe[3] = 1'b0;
    end
    if (st_next.osc_out) begin
      st_next.p0_oe[2] = 1'b0;
    end

    // Port 4 pads; an analog pin is released so the digital driver stays off
    // The release ignores direction, so no output bit fights the converter
    st_next.p4_out = st_next.dat4;
    st_next.p4_oe  = st_next.dir4 & ~p4_analog;

    // Port 5 pads; a timer function drives the pin regardless of direction
    // Software cannot silence a timer pad through its direction bit
    st_next.p5_out = st_next.dat5;
    st_next.p5_oe  = st_next.dir5;
    if (b_pulse || b_buzz) begin
      st_next.p5_out[0] = b_pulse ? TIMER_B_PULSE : TIMER_B_BUZZ;
      st_next.p5_oe[0]  = 1'b1;
    end
    if (a_pulse || a_buzz) begin
      st_next.p5_out[1] = a_pulse ? TIMER_A_PULSE : TIMER_A_BUZZ;
      st_next.p5_oe[1]  = 1'b1;
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_reg          <= '0;
      st_reg.dir0     <= DIR_RESET[3:0];
      st_reg.dir4     <= DIR_RESET[4:0];
      st_reg.dir5     <= DIR_RESET[4:3];
      st_reg.dat0     <= DATA_RESET[3:0];
      st_reg.dat4     <= DATA_RESET[4:0];
      st_reg.dat5     <= DATA_RESET[4:3];
      st_reg.edge_sel <= EDGE_RESET;
      st_reg.options  <= OPT_RESET;
      st_reg.pin_prev <= 2'b11;  // Idle-high guess avoids a false falling edge
      st_reg.bresp    <= RESP_OKAY;
      st_reg.rresp    <= RESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus handshakes; ready drops while a beat is held or a response waits
  // Ready comes from flops only, never from valid, so no loop forms
  assign S_AXI_AWREADY = !st_reg.aw_have && !st_reg.bvalid;
  assign S_AXI_WREADY  = !st_reg.w_have && !st_reg.bvalid;
  assign S_AXI_ARREADY = !st_reg.rvalid;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = {24'h000000, st_reg.rdata};
  assign S_AXI_RRESP   = st_reg.rresp;

  // Pad and select outputs straight from flip-flops
  assign P0_OUT        = st_reg.p0_out;
  assign P0_OE         = st_reg.p0_oe;
  assign P4_OUT        = st_reg.p4_out;
  assign P4_OE         = st_reg.p4_oe;
  assign P5_OUT        = st_reg.p5_out;
  assign P5_OE         = st_reg.p5_oe;
  assign ANALOG_SEL    = st_reg.analog_sel;
  assign HIGH_REF_SEL  = st_reg.high_ref;
  assign OSC_IN_SEL    = st_reg.osc_in;
  assign OSC_OUT_SEL   = st_reg.osc_out;
  assign EXT_RESET_REQ = st_reg.ext_rst;
  assign IRQ           = st_reg.irq;

endmodule : gpio_share

`default_nettype wire

// [test/gpio_share_props.sv]
// Checker for the port block: bus handshakes and pin ownership
`timescale 1ns/1ps
`default_nettype none

module gpio_share_props
  import gpio_share_pkg::*;
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Pads and shared function selects
  input wire logic [4:0]  P0_IN,
  input wire logic [3:0]  P0_OE,
  input wire logic [4:0]  P4_OE,
  input wire logic [4:0]  ANALOG_SEL,
  input wire logic        HIGH_REF_SEL,
  input wire logic        OSC_IN_SEL,
  input wire logic        OSC_OUT_SEL,
  input wire logic        EXT_RESET_REQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  // Both write halves taken together, then held off, then answered
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence wr_answer;
    ##1 (!S_AXI_AWREADY && !S_AXI_WREADY) ##1 S_AXI_BVALID;
  endsequence

  wr_timing_a: assert property (wr_taken |-> wr_answer) else $error("write answer out of time");
  bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("write answer dropped");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h0)
    else $error("read answer late or wide");
  rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer changed");
  ar_refuse_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while answer pends");
  ext_reset_a: assert property (EXT_RESET_REQ |-> !$past(P0_IN[4])) else $error("reset request without low pin");
  osc_in_a: assert property (OSC_IN_SEL |-> !P0_OE[3]) else $error("oscillator input pad driven");
  osc_out_a: assert property (OSC_OUT_SEL |-> OSC_IN_SEL && !P0_OE[2]) else $error("oscillator output misrouted");
  analog_pin_a: assert property ($onehot0(ANALOG_SEL) && (ANALOG_SEL & P4_OE) == 5'h0)
    else $error("analog channel clash");
  high_ref_a: assert property (HIGH_REF_SEL |-> !P4_OE[0]) else $error("reference pad driven");
endmodule : gpio_share_props

bind gpio_share gpio_share_props u_props (.SYS_CLK, .RESET_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
  .S_AXI_RREADY, .P0_IN, .P0_OE, .P4_OE, .ANALOG_SEL, .HIGH_REF_SEL, .OSC_IN_SEL, .OSC_OUT_SEL, .EXT_RESET_REQ);

`default_nettype wire

// [test/pin_board.sv]
// Board model: external drivers and pull-ups on the twelve pads
`timescale 1ns/1ps
`default_nettype none

module pin_board (
  // Device pad outputs
  input wire logic [3:0]  p0_out,
  input wire logic [3:0]  p0_oe,
  input wire logic [4:0]  p4_out,
  input wire logic [4:0]  p4_oe,
  input wire logic [1:0]  p5_out,
  input wire logic [1:0]  p5_oe,
  // Board drivers: bits 4:0 port 0, 9:5 port 4, 11:10 port 5
  input wire logic [11:0] drv,
  input wire logic [11:0] drv_en,
  // Pad levels seen by the device
  output logic [4:0]      p0_in,
  output logic [4:0]      p4_in,
  output logic [1:0]      p5_in
);
  logic [11:0] oe;
  logic [11:0] out;
  logic [11:0] lvl;

  // Port 0 pad 4 has no output stage at all
  assign oe  = {p5_oe, p4_oe, 1'b0, p0_oe};
  assign out = {p5_out, p4_out, 1'b0, p0_out};

  // Undriven pads float up on the board resistor; a clash is unknown, not a winner
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      if (oe[i] && drv_en[i]) lvl[i] = 1'bx;
      else if (oe[i]) lvl[i] = out[i];
      else if (drv_en[i]) lvl[i] = drv[i];
      else lvl[i] = 1'b1;
    end
  end

  assign p0_in = lvl[4:0];
  assign p4_in = lvl[9:5];
  assign p5_in = lvl[11:10];
endmodule : pin_board

`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the twelve-pin port block
`timescale 1ns/1ps
`default_nettype none

module testbench import gpio_share_pkg::*;;
  logic              clk, rst_n;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, p5_in, p5_out, p5_oe, ea_eb;
  logic [4:0]        p0_in, p4_in, p4_out, p4_oe, analog_sel, e;
  logic [3:0]        p0_out, p0_oe, wave;
  logic              high_ref, osc_in, osc_out, ext_rst, irq;
  logic [11:0]       drv, drv_en;
  logic [7:0]        rnd;
  logic [33:0]       exp_q[$];
  int                bad_count, n_checks, c;
  logic [11:0]       dir_adr[3] = '{{IDX_P0_DIR, 2'b00}, {IDX_P4_DIR, 2'b00}, {IDX_P5_DIR, 2'b00}};
  logic [7:0]        tctl[4] = '{8'h31, 8'h0a, 8'h00, 8'h27};
  logic [1:0]        t_oe[4] = '{2'b10, 2'b01, 2'b00, 2'b11};

  gpio_share uut (
    .SYS_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .P0_IN(p0_in), .P0_OUT(p0_out), .P0_OE(p0_oe), .P4_IN(p4_in), .P4_OUT(p4_out), .P4_OE(p4_oe),
    .P5_IN(p5_in), .P5_OUT(p5_out), .P5_OE(p5_oe),
    .TIMER_A_PULSE(wave[3]), .TIMER_A_BUZZ(wave[2]), .TIMER_B_PULSE(wave[1]), .TIMER_B_BUZZ(wave[0]),
    .ANALOG_SEL(analog_sel), .HIGH_REF_SEL(high_ref), .OSC_IN_SEL(osc_in), .OSC_OUT_SEL(osc_out),
    .EXT_RESET_REQ(ext_rst), .IRQ(irq));

  pin_board board (.p0_out(p0_out), .p0_oe(p0_oe), .p4_out(p4_out), .p4_oe(p4_oe), .p5_out(p5_out),
    .p5_oe(p5_oe), .drv(drv), .drv_en(drv_en), .p0_in(p0_in), .p4_in(p4_in), .p5_in(p5_in));

  // Clock at 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [33:0] ok(input logic [7:0] v);
    return {RESP_OKAY, 24'h0, v};
  endfunction : ok

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // A wait that runs dry ends the run as a mismatch
  task automatic fail_wait;
    bad_count++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask : fail_wait

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int i;
    exp_q.push_back({RESP_OKAY, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (i == 40) fail_wait();
  endtask : wr

  // Reads leave their expectation in the queue for the watcher
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [33:0] exp);
    int i;
    exp_q.push_back(exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i == 40) fail_wait();
  endtask : rd

  // Pin outputs lag their cause by one clock; two give margin
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic pin(input int b, input logic v);
    @(posedge clk);
    drv[b] <= v;
    drv_en[b] <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask : pin

  // Watcher: every read or write answer is matched with the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    {drv, drv_en, wave} = '0;
    rnd = 8'h1a;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Direction registers: reset, width, bit aliases, unmapped place
    foreach (dir_adr[k]) rd(dir_adr[k], ok(DIR_RESET));
    wr(dir_adr[0], 8'h1f);
    rd(dir_adr[0], ok(8'h0f));
    wr(ADR_P0_DATA, 8'h0a);
    settle();
    chk(34'({p0_oe, p0_out}), 34'h0fa);
    rnd = lfsr(rnd);
    wr(dir_adr[1], rnd & 8'h1f);
    wr(ADR_P4_DATA, 8'h15);
    settle();
    chk(34'({p4_oe, p4_out & p4_oe}), 34'({rnd[4:0], 5'h15 & rnd[4:0]}));
    wr(dir_adr[1], 8'h11);
    wr(ADR_DIR_SET4, 8'h04);
    rd(dir_adr[1], ok(8'h15));
    wr(ADR_DIR_CLR4, 8'h01);
    rd(dir_adr[1], ok(8'h14));
    wr(ADR_DIR_SET5, 8'h08);
    rd(dir_adr[2], ok(8'h08));
    wr(ADR_DIR_CLR5, 8'h18);
    rd(dir_adr[2], ok(8'h00));
    rd(12'h0fc, {RESP_SLVERR, 32'h0});
    // Analog channels and high reference on port 4
    wr(dir_adr[1], 8'h1f);
    for (c = 0; c < 8; c++) begin
      wr(ADR_ADC_CTRL, 8'h90 | 8'(c));
      settle();
      e = (c < 5) ? 5'(1 << c) : 5'h0;
      chk(34'({analog_sel, p4_oe}), 34'({e, ~e}));
    end
    wr(ADR_ADC_CTRL, 8'ha0);
    settle();
    chk(34'({high_ref, analog_sel, p4_oe[0]}), 34'h40);
    // Oscillator ownership for clock modes 0 to 5
    for (c = 0; c < 6; c++) begin
      wr(ADR_OPTIONS, 8'(c << 1));
      settle();
      chk(34'({osc_in, osc_out}), 34'({c inside {[1:4]}, c inside {[2:4]}}));
    end
    // Timer waveforms onto port 5, random levels
    for (c = 0; c < 4; c++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      wave <= rnd[3:0];
      wr(ADR_TIMER_CTRL, tctl[c]);
      settle();
      ea_eb = {tctl[c][4] ? rnd[3] : rnd[2], tctl[c][5] ? rnd[1] : rnd[0]};
      chk(34'({p5_oe, p5_out & p5_oe}), 34'({t_oe[c], ea_eb & t_oe[c]}));
    end
    // Interrupt flags: raise, mask, clear, edge codes 0 to 2
    wr(dir_adr[0], 8'h00);
    wr(ADR_INT_STATUS, 8'h03);
    wr(ADR_EDGE_CTRL, {6'h0, EDGE_RISE});
    pin(1, 1'b0);
    pin(0, 1'b0);
    chk(34'(irq), 34'h0);
    rd(ADR_INT_STATUS, ok(8'h02));
    pin(0, 1'b1);
    rd(ADR_INT_STATUS, ok(8'h03));
    wr(ADR_INT_MASK, 8'h01);
    settle();
    chk(34'(irq), 34'h1);
    rd(ADR_INT_MASK, ok(8'h01));
    wr(ADR_INT_STATUS, 8'h01);
    settle();
    chk(34'(irq), 34'h0);
    rd(ADR_INT_STATUS, ok(8'h02));
    wr(ADR_EDGE_CTRL, {6'h0, EDGE_BOTH});
    pin(0, 1'b0);
    rd(ADR_INT_STATUS, ok(8'h03));
    wr(ADR_INT_STATUS, 8'h03);
    wr(ADR_EDGE_CTRL, {6'h0, EDGE_FALL});
    pin(0, 1'b1);
    pin(0, 1'b0);
    rd(ADR_INT_STATUS, ok(8'h01));
    // External reset pin takes over port 0 bit 4
    wr(ADR_OPTIONS, 8'h01);
    pin(4, 1'b0);
    chk(34'(ext_rst), 34'h1);
    rd(ADR_P0_DATA, ok(8'h1c));
    wr(ADR_OPTIONS, 8'h00);
    rd(ADR_P0_DATA, ok(8'h0c));
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
